// ### rtl/mxu_defines.vh
`ifndef MXU_DEFINES_VH
`define MXU_DEFINES_VH

// Register word indices, haddr[9:2]
`define MXU_R_CMD      8'h00
`define MXU_R_STATUS   8'h01
`define MXU_R_TABLE_HIGH_BYTE_REG     8'h02
`define MXU_R_WDT      8'h03
`define MXU_R_CYC      8'h04
`define MXU_R_TBLP     8'h05
`define MXU_MEM_WIN    7
`define MXU_IDX        9:2

// Command word fields
`define MXU_F_OP       4:0
`define MXU_F_OPND     15:8
`define MXU_F_BIT      18:16
`define MXU_F_TGT      30:20

// Status word fields
`define MXU_F_ACC      7:0
`define MXU_B_C        8
`define MXU_B_AC       9
`define MXU_B_Z        10
`define MXU_B_OV       11
`define MXU_B_TO       12
`define MXU_B_PDF      13
`define MXU_B_BUSY     14
`define MXU_B_HALT     15
`define MXU_B_EMI      16
`define MXU_F_PC       27:17

// Opcodes
`define MXU_OP_NOP     5'h00
`define MXU_OP_ADD_AM  5'h01
`define MXU_OP_ADDM    5'h02
`define MXU_OP_ADD_AX  5'h03
`define MXU_OP_ADC_AM  5'h04
`define MXU_OP_ADCM    5'h05
`define MXU_OP_AND_AM  5'h06
`define MXU_OP_ANDM    5'h07
`define MXU_OP_AND_AX  5'h08
`define MXU_OP_CLR_M   5'h09
`define MXU_OP_CLR_BIT 5'h0a
`define MXU_OP_SWAP    5'h0b
`define MXU_OP_SWAPA   5'h0c
`define MXU_OP_SIZ     5'h0d
`define MXU_OP_SDZ     5'h0e
`define MXU_OP_SIZA    5'h0f
`define MXU_OP_SDZA    5'h10
`define MXU_OP_SZ_BIT  5'h11
`define MXU_OP_SNZ_BIT 5'h12
`define MXU_OP_SZA     5'h13
`define MXU_OP_CALL    5'h14
`define MXU_OP_RET     5'h15
`define MXU_OP_RETA    5'h16
`define MXU_OP_RETI    5'h17
`define MXU_OP_TABLE_READ_CURRENT_PAGE  5'h18
`define MXU_OP_TABLE_READ_LAST_PAGE  5'h19
`define MXU_OP_CLRWDT  5'h1a
`define MXU_OP_WDT1    5'h1b
`define MXU_OP_WDT2    5'h1c
`define MXU_OP_HALT    5'h1d
`define MXU_OP_JMP     5'h1e
`define MXU_OP_MOV_MA  5'h1f

// Constants
`define MXU_PCL_ADDR   7'h06
`define MXU_LAST_PAGE  3'h7
`define MXU_SP_LAST    3'h5
`define MXU_ZERO8      8'h00
`define MXU_ZERO32     32'h0000_0000
`define MXU_BIT0_MASK  8'h01
`define MXU_PC_ONE     11'h001
`define MXU_PC_TWO     11'h002
`define MXU_SP_ONE     3'h1
`define MXU_CYC_ONE    32'h0000_0001
`define MXU_WDT_ONE    16'h0001

`endif

// ### rtl/mxu_exec_unit.v
// Summary of operation
// - Skip instructions take two cycles when skipping, one cycle otherwise.
// - Any write of a result into the PC low byte takes two cycles.
// - Pre-clear pair clears watchdog, timeout and sleep flags only together.
// - Repeating the first pre-clear alone changes nothing.
// - Single watchdog clear resets counter and both flags in one cycle.
// - Call pushes PC plus one, loads target, two cycles, no flags.
// - Return, return-with-immediate, interrupt return pop PC in two cycles.
// - Current-page table read loads high part and memory byte, two cycles.
// - Last-page table read does the same from the last page.
// - Add-with-carry into accumulator updates overflow, zero, half, carry.
// - Memory-destination add-with-carry writes the sum back to memory.
// - Plain adds use no carry in, update all four arithmetic flags.
// - AND to accumulator or memory affects only the zero flag.
// - Clear-memory writes zero to the byte, flags untouched.
// - Bit-clear forces one selected bit low, nothing else changes.
// - Nibble swap writes to memory or accumulator, no flags.
// - Increment/decrement skips write result and skip when it is zero.
// - Bit-test skips on selected bit zero, or one for the inverse.
// - Zero-test move copies byte to accumulator, skips when zero.
// - Power-down stops execution, clears watchdog, sets sleep, clears timeout.
`timescale 1ns/1ns
`include "mxu_defines.vh"

module mxu_exec_unit #(
   parameter [15:0] WDT_LIMIT = 16'hffff
) (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   // Program memory read port, data one cycle after address
   output reg  [10:0] pm_addr,
   input  wire [14:0] pm_data,
   // Power-down wake pin and state
   input  wire        wake_pin,
   output reg         sleep_state
);

   localparam [3:0] ST_IDLE   = 4'b0001;
   localparam [3:0] ST_EXEC   = 4'b0010;
   localparam [3:0] ST_SECOND = 4'b0100;
   localparam [3:0] ST_HALT   = 4'b1000;

   reg  [3:0]  state;
   reg  [7:0]  dmem [0:127];
   reg  [10:0] stack [0:5];
   reg  [7:0]  acc, tblp, opnd;
   reg         c_flag, half_carry_flag, z_flag, signed_wrap_flag, emi;
   reg         watchdog_expired_flag, sleep_entered_flag;
   reg  [10:0] pc, tgt;
   reg  [2:0]  sp, bitn;
   reg  [6:0]  table_high_byte_reg;
   reg  [15:0] wdt_cnt;
   reg  [31:0] cyc;
   reg  [4:0]  op;
   reg         pre1_last, pre2_last;
   reg         wake_s1, wake_s2, wake_s3, wake_lvl;
   reg         dp_valid, dp_write, rd_done;
   reg  [7:0]  dp_addr;
   // Bus address and data phases
   wire accept = hsel & htrans[1] & hready;
   wire rd_pend = dp_valid & ~dp_write & ~rd_done;
   assign hreadyout = ~rd_pend;
   assign hresp = 1'b0;
   wire bus_wr = dp_valid & dp_write;
   wire is_reg = ~dp_addr[`MXU_MEM_WIN];
   // Software writes land only while no instruction is in flight
   wire sw_wr = bus_wr & state[0];
   wire cmd_wr = sw_wr & is_reg & (dp_addr == `MXU_R_CMD);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {dp_valid, dp_write, rd_done} <= 3'h0;
         dp_addr <= `MXU_ZERO8;
      end else if (hready) begin
         dp_valid <= accept;
         dp_write <= hwrite;
         dp_addr <= haddr[`MXU_IDX];
         rd_done <= 1'b0;
      end else begin
         rd_done <= 1'b1;
      end
   end

   // Operand fetch; the PC low byte aliases one data address
   wire [6:0]  ma = opnd[6:0];
   wire        ma_pcl = (ma == `MXU_PCL_ADDR);
   wire [7:0]  m_val = ma_pcl ? pc[7:0] : dmem[ma];
   wire [2:0]  sp_prev = (sp == 3'h0) ? `MXU_SP_LAST : sp - `MXU_SP_ONE;
   wire [2:0]  sp_next = (sp == `MXU_SP_LAST) ? 3'h0 : sp + `MXU_SP_ONE;
   wire        is_tab = (op == `MXU_OP_TABLE_READ_CURRENT_PAGE) | (op == `MXU_OP_TABLE_READ_LAST_PAGE);
   wire        step_up = (op == `MXU_OP_SIZ) | (op == `MXU_OP_SIZA);
   wire        is_ret = (op == `MXU_OP_RET) | (op == `MXU_OP_RETA) |
                        (op == `MXU_OP_RETI);
   reg  [7:0]  alu_b, res;
   reg         alu_cin, to_acc, to_mem, arith, zonly, skip;
   reg  [8:0]  sum;
   reg  [4:0]  hsum;
   always @* begin
      alu_b = m_val;
      alu_cin = 1'b0;
      res = `MXU_ZERO8;
      to_acc = 1'b0;
      to_mem = 1'b0;
      arith = 1'b0;
      zonly = 1'b0;
      skip = 1'b0;
      case (op)
         `MXU_OP_ADD_AM, `MXU_OP_ADC_AM: begin
            alu_cin = (op == `MXU_OP_ADC_AM) & c_flag;
            arith = 1'b1;
            to_acc = 1'b1;
         end
         `MXU_OP_ADDM, `MXU_OP_ADCM: begin
            alu_cin = (op == `MXU_OP_ADCM) & c_flag;
            arith = 1'b1;
            to_mem = 1'b1;
         end
         `MXU_OP_ADD_AX: begin
            alu_b = opnd;
            arith = 1'b1;
            to_acc = 1'b1;
         end
         `MXU_OP_AND_AM, `MXU_OP_ANDM: begin
            res = acc & m_val;
            zonly = 1'b1;
            to_acc = (op == `MXU_OP_AND_AM);
            to_mem = (op == `MXU_OP_ANDM);
         end
         `MXU_OP_AND_AX: begin
            res = acc & opnd;
            zonly = 1'b1;
            to_acc = 1'b1;
         end
         `MXU_OP_CLR_M: to_mem = 1'b1;
         `MXU_OP_CLR_BIT: begin
            res = m_val & ~(`MXU_BIT0_MASK << bitn);
            to_mem = 1'b1;
         end
         `MXU_OP_SWAP, `MXU_OP_SWAPA: begin
            res = {m_val[3:0], m_val[7:4]};
            to_mem = (op == `MXU_OP_SWAP);
            to_acc = (op == `MXU_OP_SWAPA);
         end
         `MXU_OP_SIZ, `MXU_OP_SDZ, `MXU_OP_SIZA, `MXU_OP_SDZA: begin
            res = step_up ? m_val + `MXU_BIT0_MASK : m_val - `MXU_BIT0_MASK;
            skip = (res == `MXU_ZERO8);
            to_mem = (op == `MXU_OP_SIZ) | (op == `MXU_OP_SDZ);
            to_acc = ~to_mem;
         end
         `MXU_OP_SZ_BIT: skip = ~m_val[bitn];
         `MXU_OP_SNZ_BIT: skip = m_val[bitn];
         `MXU_OP_SZA: begin
            res = m_val;
            to_acc = 1'b1;
            skip = (m_val == `MXU_ZERO8);
         end
         `MXU_OP_RETA: begin
            res = opnd;
            to_acc = 1'b1;
         end
         `MXU_OP_MOV_MA: begin
            res = acc;
            to_mem = 1'b1;
         end
         default: res = `MXU_ZERO8;
      endcase
      sum = {1'b0, acc} + {1'b0, alu_b} + {8'h00, alu_cin};
      hsum = {1'b0, acc[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
      if (arith)
         res = sum[7:0];
   end

   wire pcl_wr = to_mem & ma_pcl;
   wire needs_two = skip | pcl_wr | is_tab | is_ret |
                    (op == `MXU_OP_CALL) | (op == `MXU_OP_JMP);
   wire exec = state[1];

   // Watchdog pre-clear pairing in either order, back to back only
   wire pair_hit = exec & (((op == `MXU_OP_WDT2) & pre1_last) |
                           ((op == `MXU_OP_WDT1) & pre2_last));
   wire wdt_clr = pair_hit | (exec & ((op == `MXU_OP_CLRWDT) |
                                      (op == `MXU_OP_HALT)));
   wire wdt_tmo = (wdt_cnt == WDT_LIMIT);

   // Data memory and stack have no reset; contents are undefined
   // Exec, table and bus writes fall in disjoint states
   wire       mem_we = (exec & to_mem & ~pcl_wr) | (state[2] & is_tab) |
                       (sw_wr & ~is_reg);
   wire [6:0] mem_wa = state[0] ? dp_addr[6:0] : ma;
   wire [7:0] mem_wd = state[0] ? hwdata[7:0] :
                       (state[2] ? pm_data[7:0] : res);
   always @(posedge hclk) begin
      if (mem_we)
         dmem[mem_wa] <= mem_wd;
      if (exec & (op == `MXU_OP_CALL))
         stack[sp] <= pc + `MXU_PC_ONE;
   end

   // Wake pin: three stages, a change counts once stages two and three agree
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {wake_s1, wake_s2, wake_s3, wake_lvl} <= 4'h0;
      end else begin
         {wake_s3, wake_s2, wake_s1} <= {wake_s2, wake_s1, wake_pin};
         if (wake_s2 == wake_s3)
            wake_lvl <= wake_s3;
      end
   end

   // Watchdog keeps counting in power-down so a timeout can wake the core
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdt_cnt <= 16'h0000;
         watchdog_expired_flag <= 1'b0;
         sleep_entered_flag <= 1'b0;
         {pre1_last, pre2_last} <= 2'h0;
      end else begin
         if (wdt_tmo | wdt_clr)
            wdt_cnt <= 16'h0000;
         else
            wdt_cnt <= wdt_cnt + `MXU_WDT_ONE;
         // A timeout in the same cycle as a clear still sets the flag
         if (wdt_tmo)
            watchdog_expired_flag <= 1'b1;
         else if (wdt_clr)
            watchdog_expired_flag <= 1'b0;
         if (exec & (op == `MXU_OP_HALT))
            sleep_entered_flag <= 1'b1;
         else if (wdt_clr)
            sleep_entered_flag <= 1'b0;
         if (exec) begin
            pre1_last <= (op == `MXU_OP_WDT1) & ~pair_hit;
            pre2_last <= (op == `MXU_OP_WDT2) & ~pair_hit;
         end
      end
   end

   // Sequencer and core registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
         acc <= `MXU_ZERO8;
         {c_flag, half_carry_flag, z_flag, signed_wrap_flag, emi} <= 5'h00;
         {pc, pm_addr} <= 22'h00_0000;
         sp <= 3'h0;
         {tblp, table_high_byte_reg} <= 15'h0000;
         cyc <= `MXU_ZERO32;
         {op, opnd, bitn, tgt} <= 27'h000_0000;
         sleep_state <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_wr) begin
                  op <= hwdata[`MXU_F_OP];
                  opnd <= hwdata[`MXU_F_OPND];
                  bitn <= hwdata[`MXU_F_BIT];
                  tgt <= hwdata[`MXU_F_TGT];
                  if (hwdata[`MXU_F_OP] == `MXU_OP_TABLE_READ_LAST_PAGE)
                     pm_addr <= {`MXU_LAST_PAGE, tblp};
                  else
                     pm_addr <= {pc[10:8], tblp};
                  state <= ST_EXEC;
               end else if (sw_wr & (dp_addr == `MXU_R_STATUS)) begin
                  {signed_wrap_flag, z_flag, half_carry_flag, c_flag, acc}
                     <= hwdata[`MXU_B_OV:0];
                  emi <= hwdata[`MXU_B_EMI];
               end else if (sw_wr & (dp_addr == `MXU_R_TBLP)) begin
                  tblp <= hwdata[7:0];
               end
            end
            ST_EXEC: begin
               cyc <= cyc + `MXU_CYC_ONE;
               if (to_acc)
                  acc <= res;
               if (arith) begin
                  c_flag <= sum[8];
                  half_carry_flag <= hsum[4];
                  signed_wrap_flag <= (acc[7] == alu_b[7]) &
                                      (res[7] != acc[7]);
               end
               if (arith | zonly)
                  z_flag <= (res == `MXU_ZERO8);
               if (op == `MXU_OP_CALL) begin
                  pc <= tgt;
                  sp <= sp_next;
               end else if (op == `MXU_OP_JMP) begin
                  pc <= tgt;
               end else if (is_ret) begin
                  pc <= stack[sp_prev];
                  sp <= sp_prev;
               end else if (pcl_wr) begin
                  pc <= {pc[10:8], res};
               end else if (skip) begin
                  pc <= pc + `MXU_PC_TWO;
               end else begin
                  pc <= pc + `MXU_PC_ONE;
               end
               if (op == `MXU_OP_RETI)
                  emi <= 1'b1;
               if (op == `MXU_OP_HALT) begin
                  state <= ST_HALT;
                  sleep_state <= 1'b1;
               end else if (needs_two) begin
                  state <= ST_SECOND;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_SECOND: begin
               cyc <= cyc + `MXU_CYC_ONE;
               if (is_tab)
                  table_high_byte_reg <= pm_data[14:8];
               state <= ST_IDLE;
            end
            ST_HALT: begin
               if (wake_lvl | wdt_tmo) begin
                  state <= ST_IDLE;
                  sleep_state <= 1'b0;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Read data registered; every read costs one wait state
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = `MXU_ZERO32;
      if (~is_reg)
         rd_mux[7:0] = dmem[dp_addr[6:0]];
      else
         case (dp_addr)
            `MXU_R_CMD: rd_mux = {1'b0, tgt, 1'b0, bitn, opnd, 3'h0, op};
            `MXU_R_STATUS: rd_mux = {4'h0, pc, emi, state[3],
               state[1] | state[2], sleep_entered_flag,
               watchdog_expired_flag, signed_wrap_flag, z_flag,
               half_carry_flag, c_flag, acc};
            `MXU_R_TABLE_HIGH_BYTE_REG: rd_mux[6:0] = table_high_byte_reg;
            `MXU_R_WDT: rd_mux[15:0] = wdt_cnt;
            `MXU_R_CYC: rd_mux = cyc;
            `MXU_R_TBLP: rd_mux[7:0] = tblp;
            default: rd_mux = `MXU_ZERO32;
         endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= `MXU_ZERO32;
      else if (rd_pend)
         hrdata <= rd_mux;
   end

endmodule // mxu_exec_unit

// ### tb/mxu_pm_model.sv
`timescale 1ns/1ns

module mxu_pm_model (
   // Program memory port
   input  wire        hclk,
   input  wire [10:0] pm_addr,
   output reg  [14:0] pm_data
);
   // Page bits land in the high part, so a wrong page shows up
   always @(posedge hclk) begin
      pm_data <= {pm_addr[10:4], ~pm_addr[7:0]};
   end
endmodule // mxu_pm_model

// ### tb/mxu_props.sv
`timescale 1ns/1ns
`include "mxu_defines.vh"

module mxu_props #(
   parameter [15:0] WDT_LIMIT = 16'hffff
) (
   // Clock and reset
   input wire        hclk,
   input wire        hresetn,
   // Register bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [2:0]  hsize,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   // Program memory and power-down
   input wire [10:0] pm_addr,
   input wire [14:0] pm_data,
   input wire        wake_pin,
   input wire        sleep_state
);
   reg        cmd_dp;
   reg  [2:0] since;
   wire       take = hsel && htrans[1] && hready;
   wire       rd_take = take && !hwrite;
   wire [4:0] op = hwdata[`MXU_F_OP];

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Marks the data phase of a command write; since counts from it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_dp <= 1'b0;
         since  <= 3'h7;
      end else begin
         cmd_dp <= take && hwrite && haddr[`MXU_IDX] == `MXU_R_CMD;
         since  <= cmd_dp ? 3'h0 : (since == 3'h7 ? since : since + 3'h1);
      end
   end

   resp_okay_a:
      assert property (hresp == 1'b0)
      else $error("bus response not okay");
   read_wait_a:
      assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait cycle");
   write_nowait_a:
      assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   wait_cause_a:
      assert property ($fell(hreadyout) |-> $past(rd_take))
      else $error("wait state without a read");
   halt_sleep_a:
      assert property (cmd_dp && op == `MXU_OP_HALT |-> ##[1:3] sleep_state)
      else $error("power-down not entered");
   sleep_hold_a:
      assert property ($rose(sleep_state) && !wake_pin |=> sleep_state[*2])
      else $error("power-down left without cause");
   tab_last_a:
      assert property (cmd_dp && op == `MXU_OP_TABLE_READ_LAST_PAGE
                       |-> ##[1:2] pm_addr[10:8] == `MXU_LAST_PAGE)
      else $error("last-page read not on last page");
   pm_quiet_a:
      assert property (!$stable(pm_addr) |-> since < 3'h4)
      else $error("program address moved without a command");
endmodule // mxu_props

bind mxu_exec_unit mxu_props #(.WDT_LIMIT(WDT_LIMIT)) u_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .pm_addr(pm_addr), .pm_data(pm_data),
   .wake_pin(wake_pin), .sleep_state(sleep_state));

// ### tb/test_mcu_instruction_execute_unit.sv
`timescale 1ns/1ns
`include "mxu_defines.vh"

module test_mcu_instruction_execute_unit;
   localparam [31:0] A_ST  = 32'h0000_0004;
   localparam [31:0] A_TBH = 32'h0000_0008;
   localparam [31:0] A_WDT = 32'h0000_000c;
   localparam [31:0] A_CYC = 32'h0000_0010;
   localparam [31:0] A_TBP = 32'h0000_0014;
   reg         hclk;
   reg         hresetn;
   reg         hsel;
   reg  [31:0] haddr;
   reg  [1:0]  htrans;
   reg         hwrite;
   reg  [31:0] hwdata;
   reg         wake_pin;
   wire [31:0] hrdata;
   wire        hreadyout;
   wire [10:0] pm_addr;
   wire [14:0] pm_data;
   wire        sleep_state;
   integer     mismatches;
   integer     samples_checked;
   integer     k;
   reg  [31:0] v;
   reg  [31:0] st;
   reg  [31:0] cy;
   reg  [10:0] pc0;
   reg  [10:0] tg;
   reg  [10:0] e;

   mxu_exec_unit #(.WDT_LIMIT(16'h0100)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(), .pm_addr(pm_addr), .pm_data(pm_data),
      .wake_pin(wake_pin), .sleep_state(sleep_state));
   mxu_pm_model u_pm (.hclk(hclk), .pm_addr(pm_addr), .pm_data(pm_data));

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task print_verdict;
      begin
         $display("mismatches %0d checked %0d", mismatches, samples_checked);
         if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
         end else begin
            $display("TESTS FAILED");
         end
         $finish;
      end
   endtask

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
         end
      end
   endtask

   // One single transfer; waits out any wait state
   task bus(input w, input [31:0] a, input [31:0] d);
      begin
         @(posedge hclk);
         hsel <= 1'b1;
         htrans <= 2'b10;
         hwrite <= w;
         haddr <= a;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= d;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         v = hrdata;
      end
   endtask

   task wr(input [31:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rd(input [31:0] a);
      bus(1'b0, a, 32'h0000_0000);
   endtask

   function [31:0] ma(input [6:0] m);
      ma = 32'h0000_0200 + {23'h0, m, 2'b00};
   endfunction

   // Accumulator loaded, carry set, other flags cleared
   task setst(input [7:0] a);
      wr(A_ST, {23'h0, 1'b1, a});
   endtask

   task ex(input [4:0] op, input [7:0] x, input [2:0] b);
      integer i;
      begin
         rd(A_ST);
         pc0 = v[`MXU_F_PC];
         rd(A_CYC);
         cy = v;
         wr(32'h0000_0000, {1'b0, tg, 1'b0, b, x, 3'h0, op});
         i = 0;
         do begin
            rd(A_ST);
            i = i + 1;
         end while (v[`MXU_B_BUSY] !== 1'b0 && i < 40);
         st = v;
         rd(A_CYC);
         cy = v - cy;
      end
   endtask

   task sk(input [4:0] op, input [6:0] m, input [2:0] b, input [31:0] n);
      begin
         ex(op, {1'b0, m}, b);
         chk(cy, n);
         chk({21'h0, st[`MXU_F_PC] - pc0}, n);
         chk(st[11:8], 4'h1);
      end
   endtask

   task wto;
      integer i;
      begin
         i = 0;
         do begin
            rd(A_ST);
            i = i + 1;
         end while (v[`MXU_B_TO] !== 1'b1 && i < 200);
      end
   endtask

   task t_arith;
      begin
         wr(ma(7'h10), 32'h0000_007f);
         setst(8'h01);
         ex(`MXU_OP_ADC_AM, 8'h10, 3'h0);
         chk(st[11:0], 12'ha81);
         chk(cy, 1);
         setst(8'h80);
         ex(`MXU_OP_ADD_AX, 8'h80, 3'h0);
         chk(st[11:0], 12'hd00);
         wr(ma(7'h11), 32'h0000_00f0);
         setst(8'h0f);
         ex(`MXU_OP_ADCM, 8'h11, 3'h0);
         chk(st[11:0], 12'h70f);
         rd(ma(7'h11));
         chk(v, 0);
         wr(ma(7'h12), 32'h0000_0012);
         setst(8'h34);
         ex(`MXU_OP_ADDM, 8'h12, 3'h0);
         chk(st[11:0], 12'h034);
         rd(ma(7'h12));
         chk(v, 32'h0000_0046);
         setst(8'h3a);
         ex(`MXU_OP_ADD_AM, 8'h12, 3'h0);
         chk(st[11:0], 12'ha80);
      end
   endtask

   task t_logic;
      begin
         wr(ma(7'h14), 32'h0000_005a);
         setst(8'hf0);
         ex(`MXU_OP_AND_AM, 8'h14, 3'h0);
         chk(st[11:0], 12'h150);
         ex(`MXU_OP_AND_AX, 8'h0f, 3'h0);
         chk(st[11:0], 12'h500);
         setst(8'h3c);
         ex(`MXU_OP_ANDM, 8'h14, 3'h0);
         chk(st[11:0], 12'h13c);
         ex(`MXU_OP_SWAP, 8'h14, 3'h0);
         chk(st[11:0], 12'h13c);
         rd(ma(7'h14));
         chk(v, 32'h0000_0081);
         ex(`MXU_OP_SWAPA, 8'h14, 3'h0);
         chk(st[11:0], 12'h118);
         ex(`MXU_OP_CLR_BIT, 8'h14, 3'h7);
         rd(ma(7'h14));
         chk(v, 32'h0000_0001);
         ex(`MXU_OP_CLR_M, 8'h14, 3'h0);
         rd(ma(7'h14));
         chk(v, 0);
         chk(st[11:0], 12'h118);
      end
   endtask

   task t_skip;
      begin
         setst(8'h00);
         wr(ma(7'h15), 32'h0000_0000);
         sk(`MXU_OP_SZ_BIT, 7'h15, 3'h3, 2);
         sk(`MXU_OP_SNZ_BIT, 7'h15, 3'h3, 1);
         wr(ma(7'h15), 32'h0000_0008);
         sk(`MXU_OP_SNZ_BIT, 7'h15, 3'h3, 2);
         sk(`MXU_OP_SZ_BIT, 7'h15, 3'h3, 1);
         wr(ma(7'h16), 32'h0000_00ff);
         sk(`MXU_OP_SIZ, 7'h16, 3'h0, 2);
         sk(`MXU_OP_SDZ, 7'h16, 3'h0, 1);
         rd(ma(7'h16));
         chk(v, 32'h0000_00ff);
         sk(`MXU_OP_SIZA, 7'h16, 3'h0, 2);
         chk(st[7:0], 8'h00);
         sk(`MXU_OP_SDZA, 7'h15, 3'h0, 1);
         chk(st[7:0], 8'h07);
         wr(ma(7'h17), 32'h0000_0000);
         sk(`MXU_OP_SZA, 7'h17, 3'h0, 2);
         wr(ma(7'h17), 32'h0000_009c);
         sk(`MXU_OP_SZA, 7'h17, 3'h0, 1);
         chk(st[7:0], 8'h9c);
      end
   endtask

   task t_branch;
      begin
         setst(8'h42);
         for (k = 0; k < 3; k = k + 1) begin
            tg = 11'h234;
            ex(`MXU_OP_CALL, 8'h00, 3'h0);
            e = pc0 + 11'h001;
            chk(st[`MXU_F_PC], tg);
            chk({cy[7:0], st[11:8]}, 12'h021);
            ex(`MXU_OP_RET + k[4:0], 8'h77, 3'h0);
            chk(st[`MXU_F_PC], e);
            chk({cy[7:0], st[11:8]}, 12'h021);
         end
         chk(st[`MXU_B_EMI], 1);
         chk(st[7:0], 8'h77);
         ex(`MXU_OP_MOV_MA, {1'b0, `MXU_PCL_ADDR}, 3'h0);
         chk(cy, 2);
         chk(st[24:17], 8'h77);
         ex(`MXU_OP_CLR_M, {1'b0, `MXU_PCL_ADDR}, 3'h0);
         chk(cy, 2);
         chk(st[24:17], 8'h00);
      end
   endtask

   task t_table;
      begin
         tg = 11'h2a0;
         ex(`MXU_OP_JMP, 8'h00, 3'h0);
         wr(A_TBP, 32'h0000_0034);
         ex(`MXU_OP_TABLE_READ_LAST_PAGE, 8'h18, 3'h0);
         chk(cy, 2);
         chk(pm_addr, 11'h734);
         rd(ma(7'h18));
         chk(v, 32'h0000_00cb);
         rd(A_TBH);
         chk(v, 32'h0000_0073);
         ex(`MXU_OP_TABLE_READ_CURRENT_PAGE, 8'h19, 3'h0);
         e = {pc0[10:8], 8'h34};
         chk(cy, 2);
         chk(pm_addr, e);
         chk(st[11:8], 4'h1);
         rd(ma(7'h19));
         chk(v, {24'h0, ~e[7:0]});
         rd(A_TBH);
         chk(v, {25'h0, e[10:4]});
      end
   endtask

   task t_wdt;
      begin
         wto;
         ex(`MXU_OP_WDT1, 8'h00, 3'h0);
         ex(`MXU_OP_WDT1, 8'h00, 3'h0);
         chk(st[`MXU_B_TO], 1);
         ex(`MXU_OP_NOP, 8'h00, 3'h0);
         ex(`MXU_OP_WDT2, 8'h00, 3'h0);
         chk(st[`MXU_B_TO], 1);
         ex(`MXU_OP_WDT1, 8'h00, 3'h0);
         chk(st[`MXU_B_TO], 0);
         rd(A_WDT);
         chk(v[15:6], 0);
      end
   endtask

   task t_halt;
      integer i;
      begin
         wto;
         wr(32'h0000_0000, {27'h0, `MXU_OP_HALT});
         rd(A_ST);
         chk(sleep_state, 1);
         chk(v[13:12], 2'b10);
         wake_pin <= 1'b1;
         i = 0;
         while (sleep_state !== 1'b0 && i < 20) begin
            @(posedge hclk);
            i = i + 1;
         end
         wake_pin <= 1'b0;
         chk(sleep_state, 0);
         wto;
         chk(v[13:12], 2'b11);
         ex(`MXU_OP_CLRWDT, 8'h00, 3'h0);
         chk({cy[7:0], 2'b00, st[13:12]}, 12'h010);
         rd(A_WDT);
         chk(v[15:6], 0);
      end
   endtask

   // Cuts a hang well past the expected run length
   initial begin
      #(8 * 20000);
      mismatches = mismatches + 1;
      print_verdict;
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      wake_pin = 1'b0;
      tg = 11'h000;
      mismatches = 0;
      samples_checked = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(A_ST);
      chk(v, 0);
      t_arith;
      t_logic;
      t_skip;
      t_branch;
      t_table;
      t_wdt;
      t_halt;
      print_verdict;
   end
endmodule // test_mcu_instruction_execute_unit
